// ---- inc/uefr_pkg.sv ----
`default_nettype none
package uefr_pkg;
    localparam int          UEFR_NUM_EP         = 4;
    localparam logic [7:0]  UEFR_ADDR_FNUM_LOW  = 8'hba;
    localparam logic [7:0]  UEFR_ADDR_IRQ_EN    = 8'hc2;
    localparam logic [7:0]  UEFR_ADDR_FIFO_DATA = 8'hcf;
    localparam logic [7:0]  UEFR_ADDR_FIFO_RST  = 8'hd5;
    localparam logic [7:0]  UEFR_ADDR_BYTE_CNT  = 8'he2;
    localparam logic [7:0]  UEFR_ADDR_IRQ_FLAGS = 8'hf8;
    localparam logic [3:0]  UEFR_EP_RESET       = 4'h0;
    localparam logic [7:0]  UEFR_BYTE_RESET     = 8'h00;
    localparam logic [6:0]  UEFR_CNT_RESET      = 7'h00;
    localparam int          UEFR_FIFO_DEPTH     = 64;

    // Register-side access from the core's special-function-register bus
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } uefr_sfr_s;

    // Events from the serial engine, one cycle each
    typedef struct packed {
        logic [3:0] ep_event;
        logic       rx_valid;
        logic [1:0] rx_ep;
        logic [7:0] rx_byte;
        logic       rx_pkt_start;
        logic       sof_valid;
        logic [7:0] sof_frame_low;
    } uefr_link_s;
endpackage : uefr_pkg
`default_nettype wire

// ---- logic/uefr_regs.sv ----
// Behaviour
// - FIFO reset bits 0-3, upper read zero
// - Flag set on status event when enabled
// - Interrupt flag register read-only, resets zero
// - Enable bits 0-3, reset zero
// - Data window reaches selected endpoint FIFO
// - Byte count bits 6-0, bit7 zero
// - Frame number low read-only, resets zero
// - Status event raises interrupt only if enabled
`timescale 1ns/1ps
`default_nettype none
module uefr_regs
    import uefr_pkg::*;
#(
    parameter int DEPTH = UEFR_FIFO_DEPTH
) (
    input  wire logic       core_clk,
    input  wire logic       nrst,
    input  wire uefr_sfr_s  sfr,
    input  wire uefr_link_s link,
    input  wire logic [1:0] selected_endpoint,
    input  wire logic [3:0] irq_flag_clear,
    output logic      [7:0] rdata,
    output logic      [3:0] irq_flags,
    output logic      [3:0] fifo_clear_active
);
    localparam int AW = $clog2(DEPTH);

    // Pointers wrap at the depth; overflow is not guarded, so software must not overfill
    function automatic logic [AW-1:0] ptr_inc(
        input logic [AW-1:0] p
    );
        ptr_inc = p + AW'(1);
    endfunction : ptr_inc

    // Reserved upper bits of the four-endpoint registers always read zero
    function automatic logic [7:0] pad_nibble(
        input logic [3:0] v
    );
        pad_nibble = {4'h0, v};
    endfunction : pad_nibble

    logic [3:0]    fifo_rst;
    logic [3:0]    irq_en;
    logic [3:0]    irq_flag;
    logic [7:0]    frame_num_low_bits;
    logic [7:0]    fifo_mem [UEFR_NUM_EP][DEPTH];
    logic [AW-1:0] rd_ptr [UEFR_NUM_EP];
    logic [AW-1:0] wr_ptr [UEFR_NUM_EP];
    logic [6:0]    rx_byte_count [UEFR_NUM_EP];

    wire wr_fifo_rst = sfr.wr && sfr.addr == UEFR_ADDR_FIFO_RST;
    wire wr_irq_en   = sfr.wr && sfr.addr == UEFR_ADDR_IRQ_EN;
    wire wr_data     = sfr.wr && sfr.addr == UEFR_ADDR_FIFO_DATA;
    wire rd_data     = sfr.rd && sfr.addr == UEFR_ADDR_FIFO_DATA;
    wire [3:0] next_irq_flag = (irq_flag & ~irq_flag_clear) | (link.ep_event & irq_en);
    wire [7:0] fifo_byte = fifo_mem[selected_endpoint][rd_ptr[selected_endpoint]];

    function automatic logic [7:0] rd_mux(
        input logic [7:0] a,
        input logic [7:0] fb,
        input logic [6:0] cnt,
        input logic [3:0] rst,
        input logic [3:0] en,
        input logic [3:0] fl,
        input logic [7:0] fn
    );
        case (a)
            UEFR_ADDR_FIFO_RST:  rd_mux = pad_nibble(rst);
            UEFR_ADDR_IRQ_EN:    rd_mux = pad_nibble(en);
            UEFR_ADDR_IRQ_FLAGS: rd_mux = pad_nibble(fl);
            UEFR_ADDR_FIFO_DATA: rd_mux = fb;
            UEFR_ADDR_BYTE_CNT:  rd_mux = {1'b0, cnt};
            UEFR_ADDR_FNUM_LOW:  rd_mux = fn;
            default:             rd_mux = UEFR_BYTE_RESET;
        endcase
    endfunction : rd_mux

    wire [7:0] next_rdata = rd_mux(sfr.addr, fifo_byte, rx_byte_count[selected_endpoint],
                                   fifo_rst, irq_en, irq_flag, frame_num_low_bits);

    // Reset bits are plain storage; the pointer logic below watches them
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            fifo_rst <= UEFR_EP_RESET;
        end else if (wr_fifo_rst) begin
            fifo_rst <= sfr.wdata[3:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            irq_en <= UEFR_EP_RESET;
        end else if (wr_irq_en) begin
            irq_en <= sfr.wdata[3:0];
        end
    end

    // No bus write path: the flags move only by link events and the clear input
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            irq_flag <= UEFR_EP_RESET;
        end else begin
            irq_flag <= next_irq_flag;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            frame_num_low_bits <= UEFR_BYTE_RESET;
        end else if (link.sof_valid) begin
            frame_num_low_bits <= link.sof_frame_low;
        end
    end

    // Address decoded every cycle, so a read answers one edge later with no wait state
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rdata <= UEFR_BYTE_RESET;
        end else begin
            rdata <= next_rdata;
        end
    end

    assign irq_flags         = irq_flag;
    assign fifo_clear_active = fifo_rst;

    // FIFO storage is not reset; its content reads undefined until written
    always_ff @(posedge core_clk) begin
        if (wr_data) fifo_mem[selected_endpoint][wr_ptr[selected_endpoint]] <= sfr.wdata;
        if (link.rx_valid) fifo_mem[link.rx_ep][wr_ptr[link.rx_ep]] <= link.rx_byte;
    end

    // Pointers held clear while the reset bit stands, so set-then-clear empties it
    for (genvar e = 0; e < UEFR_NUM_EP; e++) begin : g_ep
        wire lw = link.rx_valid && link.rx_ep == 2'(e);
        wire sw = wr_data && selected_endpoint == 2'(e) && !lw;
        wire sr = rd_data && selected_endpoint == 2'(e);
        always_ff @(posedge core_clk) begin
            if (!nrst || fifo_rst[e]) begin
                rd_ptr[e]        <= '0;
                wr_ptr[e]        <= '0;
                rx_byte_count[e] <= UEFR_CNT_RESET;
            end else begin
                if (lw || sw) begin
                    wr_ptr[e] <= ptr_inc(wr_ptr[e]);
                end
                if (sr) begin
                    rd_ptr[e] <= ptr_inc(rd_ptr[e]);
                end
                if (link.rx_pkt_start && link.rx_ep == 2'(e)) begin
                    rx_byte_count[e] <= lw ? 7'h01 : UEFR_CNT_RESET;
                end else if (lw) begin
                    rx_byte_count[e] <= rx_byte_count[e] + 7'h01;
                end
            end
        end
    end

    a_flag_set: assert property (@(posedge core_clk) disable iff (!nrst)
        (link.ep_event[0] && irq_en[0]) |=> irq_flags[0])
        else $error("flag not set");

    // A flag event in the same cycle as a clear must survive
    a_set_wins: assert property (@(posedge core_clk) disable iff (!nrst)
        (link.ep_event[3] && irq_en[3] && irq_flag_clear[3]) |=> irq_flags[3])
        else $error("clear beat a flag event");

    a_flag_gate: assert property (@(posedge core_clk) disable iff (!nrst)
        (!irq_flag[1] && !(link.ep_event[1] && irq_en[1])) |=> !irq_flags[1])
        else $error("flag set unasked");

    a_flag_hold: assert property (@(posedge core_clk) disable iff (!nrst)
        (irq_flag[2] && !irq_flag_clear[2]) |=> irq_flags[2])
        else $error("flag dropped");

    a_flag_clear: assert property (@(posedge core_clk) disable iff (!nrst)
        (irq_flag_clear[0] && !(link.ep_event[0] && irq_en[0])) |=> !irq_flags[0])
        else $error("flag not cleared");

    a_flags_ro: assert property (@(posedge core_clk) disable iff (!nrst)
        (sfr.wr && sfr.addr == UEFR_ADDR_IRQ_FLAGS && link.ep_event == 4'h0 && irq_flag_clear == 4'h0)
        |=> irq_flags == $past(irq_flags))
        else $error("flag register written");

    a_reset_out: assert property (@(posedge core_clk)
        !nrst |=> (rdata == UEFR_BYTE_RESET && irq_flags == UEFR_EP_RESET
                   && fifo_clear_active == UEFR_EP_RESET))
        else $error("outputs not cleared by reset");

    a_upper_zero: assert property (@(posedge core_clk) disable iff (!nrst)
        (sfr.addr == UEFR_ADDR_IRQ_FLAGS || sfr.addr == UEFR_ADDR_FIFO_RST) |=> rdata[7:4] == 4'h0)
        else $error("upper bits set");

    a_en_write: assert property (@(posedge core_clk) disable iff (!nrst)
        wr_irq_en |=> irq_en == $past(sfr.wdata[3:0]))
        else $error("enable not written");

    a_cnt_bit7: assert property (@(posedge core_clk) disable iff (!nrst)
        sfr.addr == UEFR_ADDR_BYTE_CNT |=> !rdata[7])
        else $error("count bit7 set");

    a_cnt_start: assert property (@(posedge core_clk) disable iff (!nrst)
        (link.rx_pkt_start && !link.rx_valid && link.rx_ep == 2'h2 && !fifo_rst[2])
        |=> rx_byte_count[2] == UEFR_CNT_RESET)
        else $error("count not restarted");

    a_frame_low: assert property (@(posedge core_clk) disable iff (!nrst)
        link.sof_valid |=> frame_num_low_bits == $past(link.sof_frame_low))
        else $error("frame not taken");

    a_fifo_clear: assert property (@(posedge core_clk) disable iff (!nrst)
        fifo_rst[0] |=> rd_ptr[0] == '0 && wr_ptr[0] == '0 && rx_byte_count[0] == 7'h00)
        else $error("fifo not cleared");

    a_rst_reg: assert property (@(posedge core_clk) disable iff (!nrst)
        wr_fifo_rst |=> fifo_rst == $past(sfr.wdata[3:0]))
        else $error("fifo reset not written");

    a_data_read: assert property (@(posedge core_clk) disable iff (!nrst)
        rd_data |=> rdata == $past(fifo_byte))
        else $error("data read wrong");

    c_flag: cover property (@(posedge core_clk) link.ep_event[0] && irq_en[0]);
    c_rx: cover property (@(posedge core_clk) link.rx_valid ##2 link.rx_valid);
    c_clear: cover property (@(posedge core_clk) fifo_rst[1] ##1 !fifo_rst[1]);
    c_set_wins: cover property (@(posedge core_clk) link.ep_event[3] && irq_en[3] && irq_flag_clear[3]);
    c_sw_read: cover property (@(posedge core_clk) rd_data && selected_endpoint == 2'h1);
endmodule : uefr_regs
`default_nettype wire

// ---- tb/uefr_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module uefr_host
    import uefr_pkg::*;
(
    input  wire logic       core_clk,
    output var  uefr_link_s link
);
    initial link = '0;
    // One link event for a cycle, then idle with the data lines inverted so stale bytes never look valid
    task automatic put(input logic [3:0] e, input logic v, input logic [1:0] ep, input logic [7:0] b,
                       input logic s, input logic f, input logic [7:0] fn);
        @(posedge core_clk);
        link <= '{e, v, ep, b, s, f, fn};
        @(posedge core_clk);
        link <= '{4'h0, 1'b0, ep, ~b, 1'b0, 1'b0, ~fn};
    endtask : put
endmodule : uefr_host
`default_nettype wire

// ---- tb/usb_endpoint_fifo_regs_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module usb_endpoint_fifo_regs_test;
    import uefr_pkg::*;
    logic       core_clk;
    logic       nrst;
    uefr_sfr_s  sfr;
    uefr_link_s link;
    logic [1:0] sel;
    logic [3:0] clr;
    logic [7:0] rdata;
    logic [3:0] irq_flags;
    logic [3:0] fca;
    int         failures;
    int         compares;
    uefr_regs #(.DEPTH(8)) u_dut (.core_clk(core_clk), .nrst(nrst), .sfr(sfr), .link(link),
        .selected_endpoint(sel), .irq_flag_clear(clr), .rdata(rdata), .irq_flags(irq_flags),
        .fifo_clear_active(fca));
    uefr_host u_host (.core_clk(core_clk), .link(link));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        sfr <= '{1'b1, 1'b0, a, d};
        @(posedge core_clk);
        sfr.wr <= 1'b0;
    endtask : wr
    // Data lands on the same edge that takes the address, so look just past that edge
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        sfr <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge core_clk);
        sfr.rd <= 1'b0;
        #1 chk(rdata, e);
    endtask : rd
    task automatic results;
        if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    initial begin
        nrst     <= 1'b0;
        sfr      <= '0;
        sel      <= 2'h2;
        clr      <= 4'h0;
        failures = 0;
        compares = 0;
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
        rd(UEFR_ADDR_FNUM_LOW, 8'h00);
        rd(UEFR_ADDR_IRQ_EN, 8'h00);
        rd(UEFR_ADDR_FIFO_RST, 8'h00);
        rd(UEFR_ADDR_BYTE_CNT, 8'h00);
        rd(UEFR_ADDR_IRQ_FLAGS, 8'h00);
        rd(8'h00, 8'h00);
        wr(UEFR_ADDR_FIFO_RST, 8'hff);
        rd(UEFR_ADDR_FIFO_RST, 8'h0f);
        chk({4'h0, fca}, 8'h0f);
        wr(UEFR_ADDR_FIFO_RST, 8'h00);
        wr(UEFR_ADDR_IRQ_EN, 8'hff);
        rd(UEFR_ADDR_IRQ_EN, 8'h0f);
        wr(UEFR_ADDR_IRQ_EN, 8'h05);
        u_host.put(4'hf, 1'b0, 2'h2, 8'h00, 1'b0, 1'b0, 8'h00);
        rd(UEFR_ADDR_IRQ_FLAGS, 8'h05);
        chk({4'h0, irq_flags}, 8'h05);
        wr(UEFR_ADDR_IRQ_FLAGS, 8'hff);
        rd(UEFR_ADDR_IRQ_FLAGS, 8'h05);
        @(posedge core_clk) clr <= 4'hf;
        @(posedge core_clk) clr <= 4'h0;
        rd(UEFR_ADDR_IRQ_FLAGS, 8'h00);
        chk({4'h0, irq_flags}, 8'h00);
        wr(UEFR_ADDR_IRQ_EN, 8'h08);
        fork
            u_host.put(4'h8, 1'b0, 2'h2, 8'h00, 1'b0, 1'b0, 8'h00);
            begin
                @(posedge core_clk) clr <= 4'h8;
                @(posedge core_clk) clr <= 4'h0;
            end
        join
        rd(UEFR_ADDR_IRQ_FLAGS, 8'h08);
        chk({4'h0, irq_flags}, 8'h08);
        u_host.put(4'h0, 1'b0, 2'h2, 8'h00, 1'b1, 1'b0, 8'h00);
        for (int i = 0; i < 3; i++) u_host.put(4'h0, 1'b1, 2'h2, 8'h30 + 8'(i), 1'b0, 1'b0, 8'h00);
        rd(UEFR_ADDR_BYTE_CNT, 8'h03);
        for (int i = 0; i < 3; i++) rd(UEFR_ADDR_FIFO_DATA, 8'h30 + 8'(i));
        u_host.put(4'h0, 1'b1, 2'h2, 8'h77, 1'b0, 1'b0, 8'h00);
        wr(UEFR_ADDR_FIFO_RST, 8'h04);
        wr(UEFR_ADDR_FIFO_RST, 8'h00);
        rd(UEFR_ADDR_BYTE_CNT, 8'h00);
        @(posedge core_clk) sel <= 2'h1;
        wr(UEFR_ADDR_FIFO_DATA, 8'h5a);
        wr(UEFR_ADDR_FIFO_DATA, 8'hc3);
        rd(UEFR_ADDR_FIFO_DATA, 8'h5a);
        rd(UEFR_ADDR_FIFO_DATA, 8'hc3);
        rd(UEFR_ADDR_BYTE_CNT, 8'h00);
        u_host.put(4'h0, 1'b0, 2'h2, 8'h00, 1'b0, 1'b1, 8'ha5);
        rd(UEFR_ADDR_FNUM_LOW, 8'ha5);
        @(posedge core_clk) nrst <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1 chk(rdata, 8'h00);
        chk({4'h0, irq_flags}, 8'h00);
        chk({4'h0, fca}, 8'h00);
        @(posedge core_clk) nrst <= 1'b1;
        rd(UEFR_ADDR_FNUM_LOW, 8'h00);
        rd(UEFR_ADDR_IRQ_EN, 8'h00);
        rd(UEFR_ADDR_IRQ_FLAGS, 8'h00);
        results();
    end
endmodule : usb_endpoint_fifo_regs_test
`default_nettype wire
